// ---- verif/fafl_port_model.sv ----
`timescale 1ns/10ps
// ********
// Port party
// ********
module fafl_port_model (
  input logic clk_sys_i,
  output logic pclk_o = 1'b0,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0,
  output logic [35:0] data_o
);
  logic [35:0] word_r = 36'h0;
  assign data_o = wr_o ? word_r : ~word_r;
  // Enables are held well around the pin edge so the synchroniser sees them settled.
  task automatic xfer(input logic w, input logic r, input logic [35:0] d);
    @(posedge clk_sys_i);
    wr_o <= w;
    rd_o <= r;
    if (w) word_r <= d;
    repeat (2) @(posedge clk_sys_i);
    pclk_o <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    pclk_o <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
  endtask
endmodule

// ---- verif/fafl_top_sva.sv ----
`timescale 1ns/10ps
// ********
// Flag and bus drive timing, reset level and idle read data checks
// ********
module fafl_top_sva (
  input logic clk_sys_i,
  input logic rst_b_i,
  input logic port_a_clock_i,
  input logic port_b_clock_i,
  input logic porta_near_full_flag_o,
  input logic porta_near_empty_flag_o,
  input logic portb_near_empty_flag_o,
  input logic portb_near_full_flag_o,
  input logic port_b_data_bus_oe_o,
  input logic reg_rd_i,
  input logic [31:0] reg_rdata_o,
  input logic irq_o
);
  logic pin_a_r, pin_b_r;
  logic [3:0] age_a_r, age_b_r;
  // Cycles since each port pin rose; the window below allows for the two-stage synchroniser.
  always_ff @(posedge clk_sys_i) begin
    pin_a_r <= port_a_clock_i;
    pin_b_r <= port_b_clock_i;
    age_a_r <= (port_a_clock_i && !pin_a_r) ? 4'h0 : (!rst_b_i || age_a_r == 4'hF) ? 4'hF : age_a_r + 4'h1;
    age_b_r <= (port_b_clock_i && !pin_b_r) ? 4'h0 : (!rst_b_i || age_b_r == 4'hF) ? 4'hF : age_b_r + 4'h1;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  sequence rd_gap_s;
    !reg_rd_i ##1 1'b1;
  endsequence
  b_empty_sync_a: assert property ($changed(portb_near_empty_flag_o) |-> age_b_r inside {[1:7]})
    else $error("b near-empty moved away from a B edge");
  a_full_sync_a: assert property ($changed(porta_near_full_flag_o) |-> age_a_r inside {[1:7]})
    else $error("a near-full moved away from an A edge");
  b_full_sync_a: assert property ($changed(portb_near_full_flag_o) |-> age_b_r inside {[1:7]})
    else $error("b near-full moved away from a B edge");
  a_empty_sync_a: assert property ($changed(porta_near_empty_flag_o) |-> age_a_r inside {[1:7]})
    else $error("a near-empty moved away from an A edge");
  bus_drive_a: assert property ($rose(port_b_data_bus_oe_o) |-> age_b_r inside {[1:7]})
    else $error("b bus driven away from a B edge");
  rst_flags_a: assert property (!$past(rst_b_i) |-> porta_near_full_flag_o && portb_near_full_flag_o
    && !porta_near_empty_flag_o && !portb_near_empty_flag_o)
    else $error("flags wrong after reset");
  rst_quiet_a: assert property (!$past(rst_b_i) |-> !irq_o && !port_b_data_bus_oe_o)
    else $error("irq or bus drive after reset");
  rdata_gap_a: assert property (rd_gap_s |-> reg_rdata_o == 32'h0)
    else $error("read data outside read slot");
endmodule
bind fafl_top fafl_top_sva u_fafl_top_sva (.clk_sys_i, .rst_b_i, .port_a_clock_i, .port_b_clock_i,
  .porta_near_full_flag_o, .porta_near_empty_flag_o, .portb_near_empty_flag_o, .portb_near_full_flag_o,
  .port_b_data_bus_oe_o, .reg_rd_i, .reg_rdata_o, .irq_o);

// ---- verif/tb_top.sv ----
`timescale 1ns/10ps
// ********
// Bench
// ********
module tb_top;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  wire [31:0] reg_rdata_o;
  wire [35:0] a_dout, b_dout, a_din, b_din;
  wire a_clk, a_wr, a_rd, b_clk, b_wr, b_rd, b_oe, a_nf, a_ne, b_ne, b_nf, irq_o;
  int n_fail = 0;
  int tests_run = 0;
  // The far party wins while it writes, so a stale drive never reaches the queue.
  wire [35:0] b_bus = (b_oe && !b_wr) ? b_dout : b_din;
  always #12.5 clk_sys_i = ~clk_sys_i;
  fafl_top #(.DEPTH(16), .AW(4)) u_fafl_top (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .port_a_clock_i(a_clk), .port_a_wr_i(a_wr), .port_a_rd_i(a_rd), .port_a_data_i(a_din), .port_a_data_o(a_dout),
    .port_b_clock_i(b_clk), .port_b_wr_i(b_wr), .port_b_rd_i(b_rd), .port_b_data_bus_i(b_bus),
    .port_b_data_bus_o(b_dout), .port_b_data_bus_oe_o(b_oe), .porta_near_full_flag_o(a_nf),
    .porta_near_empty_flag_o(a_ne), .portb_near_empty_flag_o(b_ne), .portb_near_full_flag_o(b_nf),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));
  fafl_port_model u_port_a (.clk_sys_i(clk_sys_i), .pclk_o(a_clk), .wr_o(a_wr), .rd_o(a_rd), .data_o(a_din));
  fafl_port_model u_port_b (.clk_sys_i(clk_sys_i), .pclk_o(b_clk), .wr_o(b_wr), .rd_o(b_rd), .data_o(b_din));
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("reg_rdata", {4'h0, e}, {4'h0, reg_rdata_o});
  endtask
  task t_reset;
    chk("a_near_full", 1'b1, a_nf);
    chk("b_near_empty", 1'b0, b_ne);
    chk("b_near_full", 1'b1, b_nf);
    chk("a_near_empty", 1'b0, a_ne);
    reg_chk(8'h00, 32'h8);
    reg_chk(8'h08, 32'h8);
    reg_chk(8'h0C, 32'h8);
    reg_chk(8'h30, 32'h0);
  endtask
  task t_fill_ab;
    for (int i = 1; i <= 9; i++) begin
      u_port_a.xfer(1'b1, 1'b0, 36'hA_0000_0000 + 36'(i));
      u_port_a.xfer(1'b0, 1'b0, 36'h0);
      u_port_b.xfer(1'b0, 1'b0, 36'h0);
      chk("b_near_empty", i > 8, b_ne);
      chk("a_near_full", i < 8, a_nf);
    end
    u_port_b.xfer(1'b0, 1'b1, 36'h0);
    chk("b_bus_data", 36'hA_0000_0001, b_bus);
    chk("b_bus_oe", 1'b1, b_oe);
    u_port_b.xfer(1'b0, 1'b0, 36'h0);
    chk("b_near_empty", 1'b0, b_ne);
    reg_chk(8'h20, 32'h8);
  endtask
  task t_fill_ba;
    for (int i = 1; i <= 9; i++) begin
      u_port_b.xfer(1'b1, 1'b0, 36'hC_0000_0000 + 36'(i));
      u_port_b.xfer(1'b0, 1'b0, 36'h0);
      u_port_a.xfer(1'b0, 1'b0, 36'h0);
      chk("b_near_full", i < 8, b_nf);
      chk("a_near_empty", i > 8, a_ne);
    end
    chk("b_bus_oe", 1'b0, b_oe);
    u_port_a.xfer(1'b0, 1'b1, 36'h0);
    chk("a_data", 36'hC_0000_0001, a_dout);
    u_port_a.xfer(1'b0, 1'b0, 36'h0);
    chk("a_near_empty", 1'b0, a_ne);
    reg_chk(8'h24, 32'h8);
  endtask
  task t_irq;
    reg_chk(8'h14, 32'hF);
    chk("irq", 1'b0, irq_o);
    reg_wr(8'h1C, 32'h4);
    reg_chk(8'h1C, 32'h4);
    reg_chk(8'h18, 32'h0);
    chk("irq", 1'b1, irq_o);
    reg_wr(8'h18, 32'hB);
    reg_wr(8'h10, 32'hF);
    reg_chk(8'h10, 32'h0);
    chk("irq", 1'b1, irq_o);
    reg_wr(8'h18, 32'h4);
    reg_chk(8'h14, 32'h0);
    chk("irq", 1'b0, irq_o);
    reg_wr(8'h00, 32'h3);
    reg_wr(8'h04, 32'h3);
    reg_wr(8'h08, 32'h3);
    reg_wr(8'h0C, 32'h3);
    reg_chk(8'h04, 32'h3);
    reg_chk(8'h0C, 32'h3);
    u_port_a.xfer(1'b0, 1'b0, 36'h0);
    chk("a_near_full", 1'b1, a_nf);
    chk("a_near_empty", 1'b1, a_ne);
    u_port_b.xfer(1'b0, 1'b0, 36'h0);
    chk("b_near_empty", 1'b1, b_ne);
    chk("b_near_full", 1'b1, b_nf);
    reg_chk(8'h14, 32'h0);
  endtask
  task t_rerst;
    @(posedge clk_sys_i);
    rst_b_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    #1;
    chk("a_near_full", 1'b1, a_nf);
    chk("a_near_empty", 1'b0, a_ne);
    chk("b_near_empty", 1'b0, b_ne);
    chk("b_near_full", 1'b1, b_nf);
    chk("b_bus_oe", 1'b0, b_oe);
    chk("irq", 1'b0, irq_o);
    reg_chk(8'h20, 32'h0);
    reg_chk(8'h24, 32'h0);
    reg_chk(8'h00, 32'h8);
    reg_chk(8'h14, 32'h0);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    #1;
    t_reset;
    t_fill_ab;
    t_fill_ba;
    t_irq;
    t_rerst;
    summarize;
  end
  initial begin
    for (int k = 0; k < 20000; k++) @(posedge clk_sys_i);
    n_fail++;
    summarize;
  end
endmodule

// ---- verilog/fafl_map.vh ----
`ifndef FAFL_MAP_VH
`define FAFL_MAP_VH
// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define FAFL_OFS_AB_EMPTY 8'h00
`define FAFL_OFS_AB_FULL 8'h04
`define FAFL_OFS_BA_EMPTY 8'h08
`define FAFL_OFS_BA_FULL 8'h0C
`define FAFL_OFS_FLAGS 8'h10
`define FAFL_OFS_IRQ_STAT 8'h14
`define FAFL_OFS_IRQ_CLR 8'h18
`define FAFL_OFS_IRQ_EN 8'h1C
`define FAFL_OFS_AB_COUNT 8'h20
`define FAFL_OFS_BA_COUNT 8'h24
// ****************************************************************
// Field positions in flag, status, clear and enable registers
// ****************************************************************
`define FAFL_BIT_PB_NEAR_EMPTY 0
`define FAFL_BIT_PA_NEAR_FULL 1
`define FAFL_BIT_PB_NEAR_FULL 2
`define FAFL_BIT_PA_NEAR_EMPTY 3
// ****************************************************************
// Reset values and sizes
// ****************************************************************
`define FAFL_OFFSET_RST 16'h0008
`define FAFL_FLAGS_RST 4'h6
`define FAFL_DEPTH 1024
`define FAFL_DATA_W 36
`define FAFL_SYNC_STAGES 2
`endif

// ---- verilog/fafl_queue.v ----
`timescale 1ns/10ps
// One direction of storage; count is the number of words held.
module fafl_queue #(
  parameter DATA_W = 36,
  parameter DEPTH = 1024,
  parameter AW = 10
) (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire wr_en_i,
  input wire [DATA_W-1:0] wr_data_i,
  input wire rd_en_i,
  output reg [DATA_W-1:0] rd_data_o,
  output reg [AW:0] count_o
);
  reg [DATA_W-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  wire do_wr;
  wire do_rd;

  // Writes to a full queue and reads from an empty one are dropped.
  assign do_wr = wr_en_i && (count_o != DEPTH[AW:0]);
  assign do_rd = rd_en_i && (count_o != {(AW+1){1'b0}});

  always @(posedge clk_sys_i) begin
    if (do_wr) begin
      mem_r[wr_ptr_r] <= wr_data_i;
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_o <= {(AW+1){1'b0}};
      rd_data_o <= {DATA_W{1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_rd) begin
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
        rd_data_o <= mem_r[rd_ptr_r];
      end
      if (do_wr && !do_rd) begin
        count_o <= count_o + {{AW{1'b0}}, 1'b1};
      end else if (do_rd && !do_wr) begin
        count_o <= count_o - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ---- verilog/fafl_top.v ----
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "fafl_map.vh"

// Functional notes
// - B near-empty low if a_to_b count <= offset
// - A near-full low if a_to_b free <= offset
// - B near-full low if b_to_a free <= offset
// - Port B carries 36-bit two-way data
// - A near-empty low if b_to_a count <= offset
module fafl_top #(
  parameter DATA_W = `FAFL_DATA_W,
  parameter DEPTH = `FAFL_DEPTH,
  parameter AW = 10
) (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire port_a_clock_i,
  input wire port_a_wr_i,
  input wire port_a_rd_i,
  input wire [DATA_W-1:0] port_a_data_i,
  output reg [DATA_W-1:0] port_a_data_o,
  input wire port_b_clock_i,
  input wire port_b_wr_i,
  input wire port_b_rd_i,
  input wire [DATA_W-1:0] port_b_data_bus_i,
  output reg [DATA_W-1:0] port_b_data_bus_o,
  output reg port_b_data_bus_oe_o,
  output reg porta_near_full_flag_o,
  output reg porta_near_empty_flag_o,
  output reg portb_near_empty_flag_o,
  output reg portb_near_full_flag_o,
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  output reg irq_o
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  localparam SW = 2 * DATA_W + 6;
  wire [SW-1:0] pins_raw;
  reg [SW-1:0] pins_s1_r;
  reg [SW-1:0] pins_s2_r;
  reg pa_clk_d_r;
  reg pb_clk_d_r;
  wire pa_edge;
  wire pb_edge;
  wire pa_wr;
  wire pa_rd;
  wire pb_wr;
  wire pb_rd;
  wire [DATA_W-1:0] pa_data;
  wire [DATA_W-1:0] pb_data;

  assign pins_raw = {port_a_clock_i, port_a_wr_i, port_a_rd_i, port_b_clock_i, port_b_wr_i, port_b_rd_i,
                     port_a_data_i, port_b_data_bus_i};
  assign pa_edge = pins_s2_r[SW-1] && !pa_clk_d_r;
  assign pb_edge = pins_s2_r[SW-4] && !pb_clk_d_r;
  assign pa_wr = pa_edge && pins_s2_r[SW-2];
  assign pa_rd = pa_edge && pins_s2_r[SW-3];
  assign pb_wr = pb_edge && pins_s2_r[SW-5];
  assign pb_rd = pb_edge && pins_s2_r[SW-6];
  assign pa_data = pins_s2_r[2*DATA_W-1:DATA_W];
  assign pb_data = pins_s2_r[DATA_W-1:0];

  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      pins_s1_r <= {SW{1'b0}};
      pins_s2_r <= {SW{1'b0}};
      pa_clk_d_r <= 1'b0;
      pb_clk_d_r <= 1'b0;
    end else begin
      pins_s1_r <= pins_raw;
      pins_s2_r <= pins_s1_r;
      pa_clk_d_r <= pins_s2_r[SW-1];
      pb_clk_d_r <= pins_s2_r[SW-4];
    end
  end

  // ****************************************************************
  // Queues
  // ****************************************************************
  wire [AW:0] ab_count;
  wire [AW:0] ba_count;
  wire [DATA_W-1:0] ab_rd_data;
  wire [DATA_W-1:0] ba_rd_data;
  wire [AW:0] ab_free;
  wire [AW:0] ba_free;
  reg pb_rd_d_r;
  reg pa_rd_d_r;

  fafl_queue #(.DATA_W(DATA_W), .DEPTH(DEPTH), .AW(AW)) u_a_to_b_queue (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .wr_en_i(pa_wr),
    .wr_data_i(pa_data),
    .rd_en_i(pb_rd),
    .rd_data_o(ab_rd_data),
    .count_o(ab_count)
  );

  fafl_queue #(.DATA_W(DATA_W), .DEPTH(DEPTH), .AW(AW)) u_b_to_a_queue (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .wr_en_i(pb_wr),
    .wr_data_i(pb_data),
    .rd_en_i(pa_rd),
    .rd_data_o(ba_rd_data),
    .count_o(ba_count)
  );

  assign ab_free = DEPTH[AW:0] - ab_count;
  assign ba_free = DEPTH[AW:0] - ba_count;

  // Port B drive and Port A read data
  // The bus is driven only between a Port B read and the next Port B write, so the far party owns it otherwise.
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      pb_rd_d_r <= 1'b0;
      pa_rd_d_r <= 1'b0;
      port_b_data_bus_o <= {DATA_W{1'b0}};
      port_b_data_bus_oe_o <= 1'b0;
      port_a_data_o <= {DATA_W{1'b0}};
    end else begin
      pb_rd_d_r <= pb_rd;
      pa_rd_d_r <= pa_rd;
      if (pb_rd_d_r) begin
        port_b_data_bus_o <= ab_rd_data;
        port_b_data_bus_oe_o <= 1'b1;
      end else if (pb_wr) begin
        port_b_data_bus_oe_o <= 1'b0;
      end
      if (pa_rd_d_r) begin
        port_a_data_o <= ba_rd_data;
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [15:0] ab_empty_ofs_r;
  reg [15:0] ab_full_ofs_r;
  reg [15:0] ba_empty_ofs_r;
  reg [15:0] ba_full_ofs_r;
  reg [3:0] irq_stat_r;
  reg [3:0] irq_en_r;
  reg [3:0] irq_stat_nxt;
  reg [3:0] flags_d_r;
  wire [3:0] flags_now;
  wire [3:0] flag_event;
  wire [3:0] clr_mask;

  assign flags_now = {porta_near_empty_flag_o, portb_near_full_flag_o, porta_near_full_flag_o,
                      portb_near_empty_flag_o};
  // An event is a flag falling to its active low level.
  assign flag_event = flags_d_r & ~flags_now;
  assign clr_mask = (reg_wr_i && reg_addr_i == `FAFL_OFS_IRQ_CLR) ? reg_wdata_i[3:0] : 4'h0;

  always @* begin
    // Set wins over a clear in the same cycle.
    irq_stat_nxt = (irq_stat_r & ~clr_mask) | flag_event;
  end

  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      ab_empty_ofs_r <= `FAFL_OFFSET_RST;
      ab_full_ofs_r <= `FAFL_OFFSET_RST;
      ba_empty_ofs_r <= `FAFL_OFFSET_RST;
      ba_full_ofs_r <= `FAFL_OFFSET_RST;
      irq_en_r <= 4'h0;
      irq_stat_r <= 4'h0;
      // Matches the flag reset levels, so a release of reset raises no false event.
      flags_d_r <= `FAFL_FLAGS_RST;
      irq_o <= 1'b0;
      reg_rdata_o <= 32'h00000000;
    end else begin
      flags_d_r <= flags_now;
      irq_stat_r <= irq_stat_nxt;
      irq_o <= |(irq_stat_nxt & irq_en_r);
      if (reg_wr_i) begin
        case (reg_addr_i)
          `FAFL_OFS_AB_EMPTY: ab_empty_ofs_r <= reg_wdata_i[15:0];
          `FAFL_OFS_AB_FULL: ab_full_ofs_r <= reg_wdata_i[15:0];
          `FAFL_OFS_BA_EMPTY: ba_empty_ofs_r <= reg_wdata_i[15:0];
          `FAFL_OFS_BA_FULL: ba_full_ofs_r <= reg_wdata_i[15:0];
          `FAFL_OFS_IRQ_EN: irq_en_r <= reg_wdata_i[3:0];
          default: ;
        endcase
      end
      reg_rdata_o <= 32'h00000000;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `FAFL_OFS_AB_EMPTY: reg_rdata_o <= {16'h0000, ab_empty_ofs_r};
          `FAFL_OFS_AB_FULL: reg_rdata_o <= {16'h0000, ab_full_ofs_r};
          `FAFL_OFS_BA_EMPTY: reg_rdata_o <= {16'h0000, ba_empty_ofs_r};
          `FAFL_OFS_BA_FULL: reg_rdata_o <= {16'h0000, ba_full_ofs_r};
          `FAFL_OFS_FLAGS: reg_rdata_o <= {28'h0000000, flags_now};
          `FAFL_OFS_IRQ_STAT: reg_rdata_o <= {28'h0000000, irq_stat_r};
          `FAFL_OFS_IRQ_EN: reg_rdata_o <= {28'h0000000, irq_en_r};
          `FAFL_OFS_AB_COUNT: reg_rdata_o <= {{(31-AW){1'b0}}, ab_count};
          `FAFL_OFS_BA_COUNT: reg_rdata_o <= {{(31-AW){1'b0}}, ba_count};
          default: reg_rdata_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Near flags
  // ****************************************************************
  // Each flag moves only on its own port's clock edge, so it shows the far port's traffic only at its own port's next synchronised clock edge.
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      porta_near_full_flag_o <= 1'b1;
      porta_near_empty_flag_o <= 1'b0;
      portb_near_empty_flag_o <= 1'b0;
      portb_near_full_flag_o <= 1'b1;
    end else begin
      if (pa_edge) begin
        porta_near_full_flag_o <= !({{(15-AW){1'b0}}, ab_free} <= ab_full_ofs_r);
        porta_near_empty_flag_o <= !({{(15-AW){1'b0}}, ba_count} <= ba_empty_ofs_r);
      end
      if (pb_edge) begin
        portb_near_empty_flag_o <= !({{(15-AW){1'b0}}, ab_count} <= ab_empty_ofs_r);
        portb_near_full_flag_o <= !({{(15-AW){1'b0}}, ba_free} <= ba_full_ofs_r);
      end
    end
  end
endmodule
